// *** include/reload_pkg.sv ***
// constants for the watchdog reload value registers
package reload_pkg;
   localparam logic [11:0] ADDR_CONTROL       = 12'hFF0;
   localparam logic [11:0] ADDR_RELOAD_UPPER  = 12'hFF1;
   localparam logic [11:0] ADDR_RELOAD_MIDDLE = 12'hFF2;
   localparam logic [11:0] ADDR_RELOAD_LOW    = 12'hFF3;
   localparam logic [7:0]  RST_RELOAD_UPPER   = 8'h00;
   localparam logic [7:0]  RST_RELOAD_MIDDLE  = 8'h04;
   localparam logic [7:0]  RST_RELOAD_LOW     = 8'h00;
   localparam logic [7:0]  UNLOCK_FIRST       = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND      = 8'hAA;
   localparam logic [23:0] COUNT_TIMEOUT      = 24'h000000;
   localparam logic [23:0] COUNT_NO_REFRESH   = 24'h000002;
   localparam logic [23:0] COUNT_MAX          = 24'hFFFFFF;
   localparam int          UPPER_LSB          = 16;
   localparam int          MIDDLE_LSB         = 8;
   localparam int          LOW_LSB            = 0;
endpackage : reload_pkg

// *** include/reload_if.sv ***
// carries the stored reload value and lock walker signals between modules
`timescale 1ns/1ps
interface reload_if;
   logic [23:0] reload_value;
   logic        upper_ok;
   logic        middle_ok;
   logic        low_ok;
   modport lock (output upper_ok, output middle_ok, output low_ok, input reload_value);
   modport core (input upper_ok, input middle_ok, input low_ok, output reload_value);
endinterface : reload_if

// *** core/unlock_walker.sv ***
// lock state machine that opens the reload registers one byte at a time
`timescale 1ns/1ps
module unlock_walker
   import reload_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        wr_en_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   reload_if.lock           bus
);
   typedef enum logic [2:0] {LOCKED, GOT_FIRST, OPEN_UPPER, OPEN_MIDDLE, OPEN_LOW} lock_t;
   lock_t state_r;
   lock_t state_nxt;

   // next state: any write out of sequence falls back to locked
   always_comb begin
      state_nxt = state_r;
      if (wr_en_i) begin
         unique case (state_r)
            LOCKED:      state_nxt = (addr_i == ADDR_CONTROL && wdata_i == UNLOCK_FIRST)
                                     ? GOT_FIRST : LOCKED;
            GOT_FIRST:   state_nxt = (addr_i == ADDR_CONTROL && wdata_i == UNLOCK_SECOND)
                                     ? OPEN_UPPER : LOCKED;
            OPEN_UPPER:  state_nxt = (addr_i == ADDR_RELOAD_UPPER) ? OPEN_MIDDLE : LOCKED;
            OPEN_MIDDLE: state_nxt = (addr_i == ADDR_RELOAD_MIDDLE) ? OPEN_LOW : LOCKED;
            OPEN_LOW:    state_nxt = LOCKED;
            default:     state_nxt = LOCKED;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) state_r <= LOCKED;
      else          state_r <= state_nxt;
   end

   // byte write permissions follow the walker position
   assign bus.upper_ok  = (state_r == OPEN_UPPER);
   assign bus.middle_ok = (state_r == OPEN_MIDDLE);
   assign bus.low_ok    = (state_r == OPEN_LOW);

   a_stray_write_relocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wr_en_i && state_r == OPEN_UPPER && addr_i != ADDR_RELOAD_UPPER) |=> state_r == LOCKED)
      else $error("stray write did not relock");
endmodule : unlock_walker

// *** core/watchdog_reload.sv ***
// watchdog reload value registers with 24-bit down counter
// How it works
// - refresh instruction copies assembled reload value into the down counter
// - upper byte is bits 23:16, middle 15:8, low 7:0
// - write to a reload byte updates that stored byte
// - reading a reload byte address returns that byte of the live count
// - reset values are 00h upper, 04h middle, 00h low
// - 55h, AAh to control, then upper, middle, low; stray write relocks
// - counter counts down from reload and flags time-out at zero
// - at or below 000002h the refresh instruction is ignored
`timescale 1ns/1ps
module watchdog_reload
   import reload_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        refresh_i,
   input  wire logic        count_tick_i,
   input  wire logic        enable_i,
   output logic [7:0]       rdata_o,
   output logic             rvalid_o,
   output logic             timeout_o,
   output logic [23:0]      count_o
);
   reload_if bus();

   logic [7:0]  upper_r;
   logic [7:0]  middle_r;
   logic [7:0]  low_r;
   logic [23:0] count_r;
   logic [23:0] count_nxt;
   logic        timeout_r;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic        rvalid_r;
   logic        enable_d1_r;
   logic        enable_d2_r;
   logic        enable_seen_r;
   logic        tick_d1_r;
   logic        tick_d2_r;
   logic        tick_d3_r;

   unlock_walker u_walker (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .wr_en_i (wr_en_i),
      .addr_i  (addr_i),
      .wdata_i (wdata_i),
      .bus     (bus)
   );

   // byte select of a 24-bit value, used for reads of the live count
   function automatic logic [7:0] pick_byte(input logic [23:0] v, input logic [11:0] a);
      pick_byte = (a == ADDR_RELOAD_UPPER)  ? v[UPPER_LSB +: 8] :
                  (a == ADDR_RELOAD_MIDDLE) ? v[MIDDLE_LSB +: 8] :
                  (a == ADDR_RELOAD_LOW)    ? v[LOW_LSB +: 8] : 8'h00;
   endfunction : pick_byte

   // write strobes, gated by the walker so a locked write changes nothing
   wire wr_upper  = wr_en_i && addr_i == ADDR_RELOAD_UPPER && bus.upper_ok;
   wire wr_middle = wr_en_i && addr_i == ADDR_RELOAD_MIDDLE && bus.middle_ok;
   wire wr_low    = wr_en_i && addr_i == ADDR_RELOAD_LOW && bus.low_ok;

   // assembled reload value
   assign bus.reload_value = {upper_r, middle_r, low_r};

   // oscillator tick and enable come from outside the clock, so sync them first
   wire tick_rise = tick_d2_r && !tick_d3_r;
   wire en_rise   = enable_d2_r && !enable_seen_r;
   // refresh is refused near expiry so a late kick cannot rescue the system
   wire refresh_ok = refresh_i && enable_d2_r && count_r > COUNT_NO_REFRESH;
   wire at_zero    = count_r == COUNT_TIMEOUT;

   // counter next value: load beats decrement; zero rolls over to maximum
   always_comb begin
      count_nxt = count_r;
      if (en_rise || refresh_ok)        count_nxt = bus.reload_value;
      else if (enable_d2_r && tick_rise) count_nxt = at_zero ? COUNT_MAX : count_r - 24'h000001;
   end

   assign rdata_nxt = pick_byte(count_r, addr_i);

   // reload byte storage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         upper_r  <= RST_RELOAD_UPPER;
         middle_r <= RST_RELOAD_MIDDLE;
         low_r    <= RST_RELOAD_LOW;
      end else begin
         if (wr_upper)  upper_r  <= wdata_i;
         if (wr_middle) middle_r <= wdata_i;
         if (wr_low)    low_r    <= wdata_i;
      end
   end

   // synchronisers for the enable level and the oscillator tick
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enable_d1_r   <= 1'b0;
         enable_d2_r   <= 1'b0;
         enable_seen_r <= 1'b0;
         tick_d1_r     <= 1'b0;
         tick_d2_r     <= 1'b0;
         tick_d3_r     <= 1'b0;
      end else begin
         enable_d1_r   <= enable_i;
         enable_d2_r   <= enable_d1_r;
         enable_seen_r <= enable_d2_r;
         tick_d1_r     <= count_tick_i;
         tick_d2_r     <= tick_d1_r;
         tick_d3_r     <= tick_d2_r;
      end
   end

   // counter, time-out pulse and read data
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_r   <= {RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW};
         timeout_r <= 1'b0;
         rdata_r   <= 8'h00;
         rvalid_r  <= 1'b0;
      end else begin
         count_r   <= count_nxt;
         timeout_r <= enable_d2_r && tick_rise && !en_rise && count_r == 24'h000001;
         rdata_r   <= rd_en_i ? rdata_nxt : rdata_r;
         rvalid_r  <= rd_en_i;
      end
   end

   assign rdata_o   = rdata_r;
   assign rvalid_o  = rvalid_r;
   assign timeout_o = timeout_r;
   assign count_o   = count_r;

   a_refresh_loads: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (refresh_ok && !en_rise) |=> count_r == $past(bus.reload_value))
      else $error("refresh did not load reload value");

   a_late_refresh: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (refresh_i && count_r <= COUNT_NO_REFRESH && !en_rise && !tick_rise) |=> $stable(count_r))
      else $error("refresh accepted near expiry");

   a_read_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (rd_en_i && addr_i == ADDR_RELOAD_MIDDLE) |=> rvalid_o && rdata_o == $past(count_r[15:8]))
      else $error("read did not return count byte");

   a_locked_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wr_en_i && !bus.upper_ok && addr_i == ADDR_RELOAD_UPPER) |=> $stable(upper_r))
      else $error("locked write changed reload");

   a_write_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_upper |=> bus.reload_value[23:16] == $past(wdata_i))
      else $error("upper byte write lost");

   a_timeout_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      timeout_o |-> count_r == COUNT_TIMEOUT)
      else $error("time-out without zero count");

   a_count_down: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (enable_d2_r && tick_rise && !refresh_ok && !en_rise && !at_zero)
      |=> count_r == $past(count_r) - 24'h000001)
      else $error("counter did not decrement");

   a_reset_values: assert property (@(posedge clk_i)
      $rose(rst_b_i) |-> bus.reload_value == {RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW})
      else $error("reset reload value wrong");

   // each step of the opened walk, seen from the register side
   sequence s_upper_write;
      wr_upper;
   endsequence

   sequence s_middle_write;
      wr_middle;
   endsequence

   sequence s_low_write;
      wr_low;
   endsequence

   a_upper_opens_middle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_upper_write |=> bus.middle_ok)
      else $error("upper write did not open middle byte");

   a_middle_opens_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_middle_write |=> bus.low_ok)
      else $error("middle write did not open low byte");

   a_low_write_relocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_low_write |=> !bus.upper_ok && !bus.middle_ok && !bus.low_ok)
      else $error("low write did not relock");

   a_write_middle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_middle_write |=> bus.reload_value[15:8] == $past(wdata_i))
      else $error("middle byte write lost");

   a_write_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_low_write |=> bus.reload_value[7:0] == $past(wdata_i))
      else $error("low byte write lost");

   a_timeout_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (enable_d2_r && tick_rise && !en_rise && count_r == 24'h000001) |=> timeout_o)
      else $error("time-out missing at zero");

   a_roll_over: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (enable_d2_r && tick_rise && !en_rise && at_zero) |=> count_r == COUNT_MAX)
      else $error("counter did not roll over");

   a_enable_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      en_rise |=> count_r == $past(bus.reload_value))
      else $error("enable did not load reload value");

   a_read_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (rd_en_i && addr_i == ADDR_RELOAD_UPPER) |=> rvalid_o && rdata_o == $past(count_r[23:16]))
      else $error("upper read did not return count byte");

   a_read_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (rd_en_i && addr_i == ADDR_RELOAD_LOW) |=> rvalid_o && rdata_o == $past(count_r[7:0]))
      else $error("low read did not return count byte");

   a_read_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !rd_en_i |=> !rvalid_o && $stable(rdata_o))
      else $error("read answer without read");
endmodule : watchdog_reload

// *** testbench/watchdog_reload_test.sv ***
// self-checking bench for the watchdog reload value registers
`timescale 1ns/1ps
module watchdog_reload_test;
   import reload_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0]  wdata_i = 8'h00;
   logic        refresh_i = 1'b0;
   logic        count_tick_i = 1'b0;
   logic        enable_i = 1'b0;
   logic [7:0]  rdata_o;
   logic        rvalid_o;
   logic        timeout_o;
   logic [23:0] count_o;
   int          mismatches = 0;
   int          n_checks = 0;
   int          timeouts = 0;
   logic [23:0] reload;
   logic [23:0] nv;

   watchdog_reload watchdog_reload_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .refresh_i(refresh_i),
      .count_tick_i(count_tick_i), .enable_i(enable_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .timeout_o(timeout_o), .count_o(count_o));

   always #5 clk_i = ~clk_i;

   // expected read byte; unmapped places read as zero
   function automatic logic [7:0] byte_of(input logic [23:0] c, input logic [11:0] a);
      case (a)
         ADDR_RELOAD_UPPER:  return c[23:16];
         ADDR_RELOAD_MIDDLE: return c[15:8];
         ADDR_RELOAD_LOW:    return c[7:0];
         default:            return 8'h00;
      endcase
   endfunction : byte_of

   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_of_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // one idle cycle between writes keeps each strobe a clean pulse
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_en_i = 1'b1;
      addr_i  = a;
      wdata_i = d;
      @(negedge clk_i);
      wr_en_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [23:0] c);
      @(negedge clk_i);
      rd_en_i = 1'b1;
      addr_i  = a;
      @(negedge clk_i);
      rd_en_i = 1'b0;
      chk("read valid", 24'h000001, {23'h0, rvalid_o});
      chk("read data", {16'h0, byte_of(c, a)}, {16'h0, rdata_o});
   endtask : rd

   task automatic unlock_load(input logic [23:0] v);
      wr(ADDR_CONTROL, UNLOCK_FIRST);
      wr(ADDR_CONTROL, UNLOCK_SECOND);
      wr(ADDR_RELOAD_UPPER, v[23:16]);
      wr(ADDR_RELOAD_MIDDLE, v[15:8]);
      wr(ADDR_RELOAD_LOW, v[7:0]);
   endtask : unlock_load

   task automatic refresh_chk(input logic [23:0] exp);
      @(negedge clk_i);
      refresh_i = 1'b1;
      @(negedge clk_i);
      refresh_i = 1'b0;
      chk("count after refresh", exp, count_o);
   endtask : refresh_chk

   // ticks pass a two-stage sync, so each pulse is given five cycles
   task automatic tick_until(input logic [23:0] target);
      for (int i = 0; i < 20 && count_o !== target; i++) begin
         count_tick_i = 1'b1;
         repeat (2) @(negedge clk_i);
         count_tick_i = 1'b0;
         repeat (3) @(negedge clk_i);
      end
      chk("countdown", target, count_o);
      if (count_o !== target) end_of_test();
   endtask : tick_until

   // a time-out pulse must come with a zero count; looked at mid-cycle, where it has settled
   always @(negedge clk_i) begin
      if (timeout_o === 1'b1) begin
         timeouts++;
         chk("timeout count", 24'h000000, count_o);
      end
   end

   initial begin
      void'($urandom(19));
      repeat (8) @(negedge clk_i);
      rst_b_i = 1'b1;
      chk("reset count", 24'h000400, count_o);
      rd(ADDR_RELOAD_MIDDLE, 24'h000400);
      enable_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("enable load", {RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW}, count_o);
      // random reloads with both extremes first
      for (int i = 0; i < 8; i++) begin
         reload = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000004 : 24'($urandom);
         if (reload < 24'h000004) reload = 24'h000004;
         unlock_load(reload);
         refresh_chk(reload);
         for (int k = 0; k < 4; k++) rd(12'(ADDR_RELOAD_UPPER + k), reload);
      end
      // writes while locked must not land
      wr(ADDR_RELOAD_UPPER, ~reload[23:16]);
      wr(ADDR_RELOAD_LOW, ~reload[7:0]);
      refresh_chk(reload);
      // a stray write mid-sequence relocks the remaining bytes
      nv = 24'($urandom) | 24'h010000;
      wr(ADDR_CONTROL, UNLOCK_FIRST);
      wr(ADDR_CONTROL, UNLOCK_SECOND);
      wr(ADDR_RELOAD_UPPER, nv[23:16]);
      wr(12'h100, 8'h5A);
      wr(ADDR_RELOAD_MIDDLE, nv[15:8]);
      wr(ADDR_RELOAD_LOW, nv[7:0]);
      refresh_chk({nv[23:16], reload[15:0]});
      // count down from a small reload, refresh refused near the end
      unlock_load(24'h000005);
      refresh_chk(24'h000005);
      tick_until(24'h000003);
      refresh_chk(24'h000005);
      tick_until(COUNT_NO_REFRESH);
      refresh_chk(COUNT_NO_REFRESH);
      tick_until(COUNT_TIMEOUT);
      repeat (2) @(negedge clk_i);
      chk("timeout pulses", 24'h000001, 24'(timeouts));
      tick_until(COUNT_MAX);
      // mid-run reset brings back the reset reload value, not the last one written
      rst_b_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_b_i = 1'b1;
      chk("reset count", {RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW}, count_o);
      repeat (6) @(negedge clk_i);
      tick_until(24'h0003FF);
      refresh_chk({RST_RELOAD_UPPER, RST_RELOAD_MIDDLE, RST_RELOAD_LOW});
      end_of_test();
   end
endmodule : watchdog_reload_test
